// *** asrp_pkg.sv ***
// Package for the serial register port of a dual measurement converter.
// Assumes a single system clock domain; serial pins are sampled.
package asrp_pkg;

  // ==========================================================
  // Register selection and widths
  localparam int ASRP_ADDR_W = 4;
  localparam logic [3:0] ASRP_REG_COMM = 4'h0;
  localparam logic [3:0] ASRP_REG_STATUS = 4'h0;
  localparam logic [3:0] ASRP_REG_MODE = 4'h1;
  localparam logic [3:0] ASRP_REG_MAIN_CTL = 4'h2;
  localparam logic [3:0] ASRP_REG_AUX_CTL = 4'h3;
  localparam logic [3:0] ASRP_REG_MAIN_DATA = 4'h4;
  localparam logic [3:0] ASRP_REG_AUX_DATA = 4'h5;
  localparam int ASRP_NUM_REGS = 16;
  localparam int ASRP_MAX_W = 24;
  localparam logic [4:0] ASRP_MAIN_DATA_W = 5'h18;
  localparam logic [4:0] ASRP_AUX_DATA_W = 5'h10;
  localparam logic [4:0] ASRP_BYTE_W = 5'h08;

  // ==========================================================
  // Communications word fields
  localparam int ASRP_COMM_RW_BIT = 6;
  localparam int ASRP_COMM_ADDR_LSB = 0;
  localparam int ASRP_STAT_MAIN_RDY_BIT = 7;
  localparam int ASRP_STAT_AUX_RDY_BIT = 6;
  localparam logic [7:0] ASRP_REG_RESET_VAL = 8'h00;

  // ==========================================================
  // Interface reset and timing
  localparam logic [5:0] ASRP_ONES_RESET = 6'h20;

  typedef enum logic [1:0] {
    ASRP_ST_COMM = 2'b00,
    ASRP_ST_WRITE = 2'b01,
    ASRP_ST_READ = 2'b10
  } asrp_state_e;

  // Result word offered by a converter
  typedef struct packed {
    logic main_valid;
    logic aux_valid;
    logic [23:0] main_word;
    logic [15:0] aux_word;
  } asrp_result_s;

endpackage

// *** asrp_port.sv ***
// Serial register port: comm-register gated access, ready strobe, resets.
// Assumes serial pins asynchronous to clk_sys, with sclk much slower.
//
// Overview of operation
// (R1) Host begins every transaction by writing the communications register.
// (R2) After reset the next transfer is a communications register write.
// (R3) Communications word selects read or write and target register.
// (R4) Register write: communications write then write transfer.
// (R5) Register read: communications write then read transfer.
// (R6) Data in on serial input, out on serial output, timed by sclk.
// (R7) Falling sclk edge is the active shifting edge.
// (R8) Data-ready goes low when either converter has a new result.
// (R9) Data-ready returns high after both results are read.
// (R10) Data-ready rises before the output register is updated; the port raises rdy_n on the same clk_sys edge as the update.
// (R11) Same result may be read again while data-ready is high.
// (R12) Low chip select enables device; held low gives three-wire mode.
// (R13) Status register exposes main and aux ready flags.
// (R14) Chip select falling edge presents the output MSB.
// (R15) Host may keep sclk running between frames.
// (R16) Microcontroller hosts should idle sclk high.
// (R17) Reset input resets the serial interface.
// (R18) 32 consecutive ones on serial input reset the interface.
// (R19) After ones reset, await comm write; registers take power-on values.
// (R20) Shared-line hosts recover by 24-clock read then 32 ones.
// (R21) Reset pin returns the whole converter to power-on state.
// (R22) Words shift MSB first, length set by selected register.
// (R23) Serial output released while chip select is high.
`timescale 1ns/1ps
`default_nettype none
module asrp_port #(
  parameter int SYNC_STAGES = 3
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output logic rdy_n,
  input wire asrp_pkg::asrp_result_s result_in,
  output logic result_ready,
  output logic [7:0] mode_ctl,
  output logic [7:0] main_ctl,
  output logic [7:0] aux_ctl
);
  import asrp_pkg::*;

  // ==========================================================
  // Reset release and pin sampling
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [2:0] cs_sync;
  logic [2:0] sclk_sync;
  logic [2:0] sdi_sync;
  logic cs_q;
  logic sclk_q;
  logic sdi_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync <= 3'h7;
      sclk_sync <= 3'h7;
      sdi_sync <= 3'h0;
      cs_q <= 1'b1;
      sclk_q <= 1'b1;
      sdi_q <= 1'b0;
    end else if (clk_en) begin
      cs_sync <= {cs_sync[1:0], cs_n};
      sclk_sync <= {sclk_sync[1:0], sclk};
      sdi_sync <= {sdi_sync[1:0], sdi};
      if (cs_sync[1] == cs_sync[2]) cs_q <= cs_sync[2];
      if (sclk_sync[1] == sclk_sync[2]) sclk_q <= sclk_sync[2];
      if (sdi_sync[1] == sdi_sync[2]) sdi_q <= sdi_sync[2];
    end
  end

  logic cs_prev;
  logic sclk_prev;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev <= 1'b1;
      sclk_prev <= 1'b1;
    end else if (clk_en) begin
      cs_prev <= cs_q;
      sclk_prev <= sclk_q;
    end
  end

  logic selected;
  logic sclk_fall;
  logic sclk_rise;
  logic cs_fall;
  assign selected = !cs_q; // R12
  assign sclk_fall = sclk_prev && !sclk_q && selected; // R7
  assign sclk_rise = !sclk_prev && sclk_q && selected;
  assign cs_fall = cs_prev && !cs_q;

  // ==========================================================
  // Result buffer: two entries, drained into the output registers
  asrp_result_s buf_mem [2];
  logic buf_wr;
  logic buf_rd;
  logic [1:0] buf_cnt;
  logic buf_wptr;
  logic buf_rptr;
  logic buf_valid;
  logic buf_ready;
  assign buf_valid = buf_cnt != 2'd0;
  assign buf_ready = buf_cnt != 2'd2;
  assign buf_wr = (result_in.main_valid || result_in.aux_valid) && buf_ready;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_ready <= 1'b0;
    end else if (clk_en) begin
      result_ready <= buf_cnt == 2'd0 || (buf_cnt == 2'd1 && !buf_wr);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_cnt <= 2'd0;
      buf_wptr <= 1'b0;
      buf_rptr <= 1'b0;
    end else if (clk_en) begin
      if (buf_wr) buf_wptr <= !buf_wptr;
      if (buf_rd) buf_rptr <= !buf_rptr;
      buf_cnt <= buf_cnt + {1'b0, buf_wr} - {1'b0, buf_rd};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && buf_wr) buf_mem[buf_wptr] <= result_in;
  end

  // ==========================================================
  // Serial engine
  asrp_state_e state;
  logic [23:0] shift_in;
  logic [23:0] shift_out;
  logic [4:0] bit_cnt;
  logic [4:0] word_len;
  logic [3:0] target;
  logic [5:0] ones_cnt;
  logic ones_reset;
  logic reading_data;
  logic main_rdy;
  logic aux_rdy;
  logic [23:0] main_out;
  logic [15:0] aux_out;
  logic [7:0] next_comm;
  logic last_bit;

  assign next_comm = {shift_in[6:0], sdi_q};
  assign last_bit = bit_cnt == word_len - 5'd1;
  assign ones_reset = sclk_rise && sdi_q && ones_cnt == ASRP_ONES_RESET - 6'd1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ones_cnt <= 6'd0;
    end else if (clk_en && sclk_rise) begin
      if (!sdi_q) ones_cnt <= 6'd0;
      else if (ones_cnt != ASRP_ONES_RESET - 6'd1) ones_cnt <= ones_cnt + 6'd1;
      else ones_cnt <= 6'd0; // R18
    end
  end

  function automatic logic [4:0] asrp_len(input logic [3:0] addr);
    case (addr)
      ASRP_REG_MAIN_DATA: asrp_len = ASRP_MAIN_DATA_W;
      ASRP_REG_AUX_DATA: asrp_len = ASRP_AUX_DATA_W;
      default: asrp_len = ASRP_BYTE_W;
    endcase
  endfunction

  logic [23:0] read_word;
  always_comb begin
    case (target)
      ASRP_REG_STATUS: read_word = {main_rdy, aux_rdy, 6'h00, 16'h0000}; // R13
      ASRP_REG_MODE: read_word = {mode_ctl, 16'h0000};
      ASRP_REG_MAIN_CTL: read_word = {main_ctl, 16'h0000};
      ASRP_REG_AUX_CTL: read_word = {aux_ctl, 16'h0000};
      ASRP_REG_MAIN_DATA: read_word = main_out;
      ASRP_REG_AUX_DATA: read_word = {aux_out, 8'h00};
      default: read_word = 24'h000000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ASRP_ST_COMM; // R2 R17
      bit_cnt <= 5'd0;
      word_len <= ASRP_BYTE_W;
      target <= 4'h0;
      shift_in <= 24'h000000;
      shift_out <= 24'h000000;
      reading_data <= 1'b0;
      mode_ctl <= ASRP_REG_RESET_VAL;
      main_ctl <= ASRP_REG_RESET_VAL;
      aux_ctl <= ASRP_REG_RESET_VAL; // R21
    end else if (clk_en) begin
      reading_data <= 1'b0;
      if (ones_reset) begin
        state <= ASRP_ST_COMM; // R19
        bit_cnt <= 5'd0;
        word_len <= ASRP_BYTE_W;
        mode_ctl <= ASRP_REG_RESET_VAL;
        main_ctl <= ASRP_REG_RESET_VAL;
        aux_ctl <= ASRP_REG_RESET_VAL;
      end else if (cs_fall && state == ASRP_ST_READ) begin
        shift_out <= read_word; // R14
      end else if (sclk_rise && state != ASRP_ST_READ) begin
        shift_in <= {shift_in[22:0], sdi_q}; // R6 R22
        bit_cnt <= last_bit ? 5'd0 : bit_cnt + 5'd1;
        if (last_bit) begin
          case (state)
            ASRP_ST_COMM: begin
              target <= next_comm[ASRP_COMM_ADDR_LSB +: ASRP_ADDR_W]; // R3
              word_len <= asrp_len(next_comm[3:0]);
              if (next_comm[ASRP_COMM_RW_BIT]) begin
                state <= ASRP_ST_READ; // R5
                shift_out <= 24'h000000;
              end else if (next_comm[3:0] != ASRP_REG_COMM) begin
                state <= ASRP_ST_WRITE; // R4
              end
            end
            ASRP_ST_WRITE: begin
              state <= ASRP_ST_COMM; // R1
              word_len <= ASRP_BYTE_W;
              case (target)
                ASRP_REG_MODE: mode_ctl <= next_comm;
                ASRP_REG_MAIN_CTL: main_ctl <= next_comm;
                ASRP_REG_AUX_CTL: aux_ctl <= next_comm;
                default: ;
              endcase
            end
            default: state <= ASRP_ST_COMM;
          endcase
        end
      end else if (state == ASRP_ST_READ && sclk_fall) begin
        // First falling edge presents the MSB, later ones shift it on
        if (bit_cnt == 5'd0) begin
          shift_out <= read_word; // R7 R22
        end else begin
          shift_out <= {shift_out[22:0], 1'b0};
        end
      end else if (state == ASRP_ST_READ && sclk_rise) begin
        // Bits are counted on the host's sampling edge so the closing
        // rising edge is not taken as the first bit of the next command
        bit_cnt <= last_bit ? 5'd0 : bit_cnt + 5'd1;
        if (last_bit) begin
          state <= ASRP_ST_COMM;
          word_len <= ASRP_BYTE_W;
          reading_data <= target == ASRP_REG_MAIN_DATA ||
            target == ASRP_REG_AUX_DATA;
        end
      end
    end
  end

  // ==========================================================
  // Serial output and release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (clk_en) begin
      sdo_oe_n <= !(selected && state == ASRP_ST_READ); // R23
      if (state == ASRP_ST_READ && bit_cnt == 5'd0) sdo <= read_word[23];
      else sdo <= shift_out[23];
    end
  end

  // ==========================================================
  // Result registers and data-ready
  logic read_main;
  logic read_aux;
  logic busy;
  assign busy = state == ASRP_ST_READ && bit_cnt != 5'd0;
  assign buf_rd = buf_valid && !busy && !reading_data;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_out <= 24'h000000;
      aux_out <= 16'h0000;
      main_rdy <= 1'b0;
      aux_rdy <= 1'b0;
      read_main <= 1'b0;
      read_aux <= 1'b0;
      rdy_n <= 1'b1;
    end else if (clk_en) begin
      if (ones_reset) begin
        main_rdy <= 1'b0;
        aux_rdy <= 1'b0;
        rdy_n <= 1'b1;
      end else if (buf_rd) begin
        rdy_n <= 1'b1; // R10
        if (buf_mem[buf_rptr].main_valid) begin
          main_out <= buf_mem[buf_rptr].main_word;
          main_rdy <= 1'b1;
          read_main <= 1'b0;
        end
        if (buf_mem[buf_rptr].aux_valid) begin
          aux_out <= buf_mem[buf_rptr].aux_word;
          aux_rdy <= 1'b1;
          read_aux <= 1'b0;
        end
      end else if (reading_data) begin
        if (target == ASRP_REG_MAIN_DATA) read_main <= 1'b1; // R11
        else read_aux <= 1'b1;
        if ((target == ASRP_REG_MAIN_DATA || read_main || !main_rdy) &&
            (target == ASRP_REG_AUX_DATA || read_aux || !aux_rdy)) begin
          rdy_n <= 1'b1; // R9
          main_rdy <= 1'b0;
          aux_rdy <= 1'b0;
        end
      end else if (main_rdy || aux_rdy) begin
        rdy_n <= 1'b0; // R8
      end
    end
  end

endmodule
`default_nettype wire

// *** asrp_port_checker.sv ***
// Pin-level checks for the serial register port, bound to asrp_port.
// Assumes one clk_sys domain and sclk far slower than clk_sys.
`timescale 1ns/1ps
`default_nettype none
module asrp_port_checker
  import asrp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  input wire logic rdy_n,
  input wire asrp_pkg::asrp_result_s result_in,
  input wire logic result_ready,
  input wire logic [7:0] mode_ctl,
  input wire logic [7:0] main_ctl,
  input wire logic [7:0] aux_ctl
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Run of ones seen on rising sclk inside a frame
  logic sclk_q;
  logic rise;
  logic [5:0] ones;
  assign rise = sclk && !sclk_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b1;
      ones <= 6'h00;
    end else begin
      sclk_q <= sclk;
      ones <= (cs_n || (rise && !sdi)) ? 6'h00 :
        ones + {5'h00, rise && ones != ASRP_ONES_RESET};
    end
  end
  sequence ones_run;
    $rose(ones == ASRP_ONES_RESET);
  endsequence
  sequence cfg_clear;
    ##[1:24] ({mode_ctl, main_ctl, aux_ctl} == 24'h000000);
  endsequence
  // ==========================================================
  // Assertions
  ones_clear_a: assert property (ones_run |-> cfg_clear)
    else $error("config kept after ones run");
  oe_idle_a: assert property (cs_n [*8] |-> sdo_oe_n)
    else $error("output driven while deselected");
  cfg_hold_a: assert property (cs_n [*8] |=> $stable({mode_ctl, main_ctl, aux_ctl}))
    else $error("config changed while deselected");
  reset_out_a: assert property ($rose(reset_n) |-> rdy_n && sdo_oe_n && mode_ctl == 8'h00)
    else $error("bad output state after reset");
  ready_up_a: assert property ($rose(reset_n) |-> ##[1:6] result_ready)
    else $error("result buffer not ready after reset");
  rdy_low_a: assert property (result_in.main_valid && result_ready |-> ##[1:1000] !rdy_n)
    else $error("data ready not signalled");
  oe_sel_a: assert property (!sdo_oe_n |-> !$past(cs_n, 8))
    else $error("output driven without selection");
  sdo_hold_a: assert property ((sclk && !cs_n && !sdo_oe_n) [*8] |=> $stable(sdo))
    else $error("output changed while sclk high");
endmodule
bind asrp_port asrp_port_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .clk_en(clk_en), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
  .sdo_oe_n(sdo_oe_n), .rdy_n(rdy_n), .result_in(result_in),
  .result_ready(result_ready), .mode_ctl(mode_ctl), .main_ctl(main_ctl),
  .aux_ctl(aux_ctl));
`default_nettype wire

// *** asrp_host_model.sv ***
// Host serial port model driving select, serial clock and serial input.
// Assumes clk_sys at 250 MHz; sclk half period is 16 clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
module asrp_host_model (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // ==========================================================
  // One framed transfer, MSB first; released output reads as X
  task automatic xfer(input int n, input logic [31:0] d,
                      output logic [31:0] q);
    q = '0;
    cs_n <= 1'b0;
    wt(16);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b0;
      sdi <= d[i];
      wt(16);
      q = {q[30:0], sdo_oe_n ? 1'bx : sdo};
      sclk <= 1'b1;
      wt(16);
    end
    cs_n <= 1'b1;
    sdi <= ~sdi;
    wt(16);
    sclk <= 1'b0;
    wt(16);
    sclk <= 1'b1;
    wt(16);
  endtask
endmodule
`default_nettype wire

// *** asrp_port_bench.sv ***
// Self-checking bench for the serial register port.
// Assumes asrp_host_model as far side and the bound pin checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
  err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
  end end
module asrp_port_bench;
  import asrp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic cs_n, sclk, sdi, sdo, sdo_oe_n, rdy_n, result_ready;
  asrp_result_s result_in = '0;
  logic [7:0] mode_ctl, main_ctl, aux_ctl;
  logic [31:0] q;
  int err_count = 0;
  int n_tests = 0;
  always #2 clk_sys = ~clk_sys;
  asrp_port dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .rdy_n(rdy_n), .result_in(result_in), .result_ready(result_ready),
    .mode_ctl(mode_ctl), .main_ctl(main_ctl), .aux_ctl(aux_ctl));
  asrp_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
  // ==========================================================
  // Shared tasks
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    host.xfer(16, {16'h0000, 4'h0, a, v}, q);
  endtask
  task automatic rd(input logic [3:0] a, input int n);
    host.xfer(8 + n, {24'h000000, 4'h4, a} << n, q);
  endtask
  task automatic wait_rdy(input logic lvl);
    int k;
    k = 0;
    while (rdy_n !== lvl && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK("rdy_n", lvl, rdy_n)
    if (k == 3000) end_of_test;
  endtask
  task automatic offer(input logic [23:0] m, input logic [15:0] a);
    int k;
    k = 0;
    while (result_ready !== 1'b1 && k < 100) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == 100) begin
      err_count++;
      end_of_test;
    end
    result_in <= '{1'b1, 1'b1, m, a};
    @(posedge clk_sys);
    result_in <= '0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    `CHK("rdy_n", 1'b1, rdy_n)
    `CHK("sdo_oe_n", 1'b1, sdo_oe_n)
    `CHK("ctl", 24'h000000, {mode_ctl, main_ctl, aux_ctl})
  endtask
  task automatic t_write;
    wr(ASRP_REG_MODE, 8'h5a);
    wr(ASRP_REG_MAIN_CTL, 8'hc3);
    wr(ASRP_REG_AUX_CTL, 8'h81);
    `CHK("ctl", 24'h5ac381, {mode_ctl, main_ctl, aux_ctl})
  endtask
  task automatic t_result;
    offer(24'ha5c31e, 16'h5a3c);
    wait_rdy(1'b0);
    rd(ASRP_REG_STATUS, 8);
    `CHK("status", 2'b11, q[7:6])
    rd(ASRP_REG_MAIN_DATA, 24);
    `CHK("main", 24'ha5c31e, q[23:0])
    `CHK("rdy_n mid", 1'b0, rdy_n)
    rd(ASRP_REG_AUX_DATA, 16);
    `CHK("aux", 16'h5a3c, q[15:0])
    wait_rdy(1'b1);
    rd(ASRP_REG_MAIN_DATA, 24);
    `CHK("main again", 24'ha5c31e, q[23:0])
    `CHK("rdy_n after", 1'b1, rdy_n)
  endtask
  task automatic t_ones;
    host.xfer(24, 32'h00000000, q);
    host.xfer(32, 32'hffffffff, q);
    `CHK("ctl", 24'h000000, {mode_ctl, main_ctl, aux_ctl})
    wr(ASRP_REG_MAIN_CTL, 8'h66);
    `CHK("main_ctl", 8'h66, main_ctl)
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    t_reset;
    t_write;
    t_result;
    t_ones;
    end_of_test;
  end
endmodule
`default_nettype wire
